/* src/fac_top.sv */
// fault alert, telemetry and parametric capture logic
`timescale 1ns/1ps
`default_nettype none
`include "fac_params.svh"
// Contract
// - pull alert low on enabled active fault
// - alert stays low while faults remain
// - telemetry readable at any time
// - capture active only when setup bit 1
// - capture read as 22 byte block
// - store value 1 loads saved set
// - store value 2 saves when disabled
// - shutdown fault saves capture automatically; the code saves only when that fault's alert enable bit is set
// - retry faults never trigger save
// - save takes 700 to 1400 us
// - check stores at initialization
// - default restore allowed, factory may be withheld
module fac_top #(
  parameter int SAVE_MIN = `FAC_SAVE_MIN_CYC,
  parameter int SAVE_MAX = `FAC_SAVE_MAX_CYC
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  // faults, from pins
  input wire logic [7:0] FAULT_IN,
  input wire logic [7:0] FAULT_ALERT_EN_IN,
  input wire logic [7:0] FAULT_SHUTDOWN_IN,
  input wire logic OUTPUT_ENABLED_IN,
  // alert response
  input wire logic ARA_ACK_IN,
  output logic FAULT_ALERT_LINE_N_OUT,
  output logic FAULT_ALERT_LINE_OE_OUT,
  // telemetry
  input wire logic [15:0] VIN_IN,
  input wire logic [15:0] VOUT_IN,
  input wire logic [15:0] IOUT_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic [15:0] FREQ_IN,
  input wire logic [15:0] DUTY_IN,
  input wire logic [2:0] TLM_SEL_IN,
  output logic [15:0] TLM_DATA_OUT,
  // capture control
  input wire logic [7:0] MISC_SETUP_IN,
  input wire logic STORE_WR_IN,
  input wire logic [7:0] STORE_DATA_IN,
  input wire logic BLOCK_PREP_IN,
  input wire logic CAP_RD_IN,
  output logic [7:0] CAP_BYTE_OUT,
  output logic CAP_VALID_OUT,
  output logic CAP_LAST_OUT,
  output logic NVM_BUSY_OUT,
  // stores
  input wire logic DEFAULT_STORED_IN,
  input wire logic USER_STORED_IN,
  input wire logic RESTORE_DEFAULT_IN,
  input wire logic RESTORE_FACTORY_IN,
  input wire logic FACTORY_ALLOWED_IN,
  output logic [1:0] CFG_SRC_OUT,
  output logic INIT_DONE_OUT,
  output logic RESTORE_DONE_OUT
);
  logic rst_s1_q, rst_n;
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // fault and ack pin inputs through two flops
  logic [7:0] flt_s1_q, flt_q;
  logic ack_s1_q, ack_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      flt_s1_q <= 8'h00;
      flt_q <= 8'h00;
      ack_s1_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      flt_s1_q <= FAULT_IN;
      flt_q <= flt_s1_q;
      ack_s1_q <= ARA_ACK_IN;
      ack_q <= ack_s1_q;
    end
  end

  // alert: new enabled fault asserts; ack releases only if no fault left
  logic [7:0] flt_prev_q;
  logic [7:0] act;
  logic alert_q;
  assign act = flt_q & FAULT_ALERT_EN_IN;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      flt_prev_q <= 8'h00;
      alert_q <= 1'b0;
    end else begin
      flt_prev_q <= act;
      if (|(act & ~flt_prev_q)) begin
        alert_q <= 1'b1;
      end else if (ack_q && act == 8'h00) begin
        alert_q <= 1'b0;
      end
      // an ack with faults still active leaves the line low
    end
  end
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      FAULT_ALERT_LINE_N_OUT <= 1'b1;
      FAULT_ALERT_LINE_OE_OUT <= 1'b0;
    end else begin
      FAULT_ALERT_LINE_N_OUT <= 1'b0;
      FAULT_ALERT_LINE_OE_OUT <= alert_q;
    end
  end

  // telemetry mux, always live
  function automatic logic [15:0] tlm_pick(input logic [2:0] s, input logic [95:0] v);
    tlm_pick = (s < 3'd6) ? v[16*s +: 16] : 16'h0000;
  endfunction
  logic [95:0] tlm_all;
  assign tlm_all = {DUTY_IN, FREQ_IN, TEMP_IN, IOUT_IN, VOUT_IN, VIN_IN};
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      TLM_DATA_OUT <= 16'h0000;
    end else begin
      TLM_DATA_OUT <= tlm_pick(TLM_SEL_IN, tlm_all);
    end
  end

  // capture RAM and non-volatile copy
  logic [7:0] ram_q [`FAC_CAP_BYTES];
  logic [7:0] nvm_q [`FAC_CAP_BYTES];
  logic cap_en;
  assign cap_en = MISC_SETUP_IN[`FAC_MISC_CAP_BIT];
  logic [7:0] live [`FAC_CAP_BYTES];
  always_comb begin
    for (int i = 0; i < `FAC_CAP_BYTES; i++) begin
      live[i] = (i < 12) ? tlm_all[8*i +: 8] : (i == 12 ? flt_q : 8'h00);
    end
  end

  fac_pkg::fac_state_type st_q;
  logic [4:0] idx_q;
  logic [4:0] init_q;
  logic tmr_start, tmr_done, auto_save;
  assign auto_save = cap_en && |(act & FAULT_SHUTDOWN_IN & ~flt_prev_q);
  assign tmr_start = (st_q == fac_pkg::ST_SAVE);

  fac_nvm_timer #(.SAVE_MIN(SAVE_MIN), .SAVE_MAX(SAVE_MAX)) u_tmr (
    .clk_in(MCLK_IN),
    .rst_n_in(rst_n),
    .start_in(tmr_start),
    .block_in(BLOCK_PREP_IN),
    .done_out(tmr_done)
  );

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= fac_pkg::ST_INIT;
      idx_q <= 5'd0;
      init_q <= 5'd0;
    end else begin
      case (st_q)
        fac_pkg::ST_INIT: begin
          init_q <= init_q + 5'd1;
          if (init_q == 5'(`FAC_INIT_CYC - 1)) begin
            st_q <= fac_pkg::ST_IDLE;
          end
        end
        fac_pkg::ST_IDLE: begin
          if (auto_save) begin
            st_q <= fac_pkg::ST_SAVE;
          end else if (cap_en && STORE_WR_IN && STORE_DATA_IN == `FAC_STORE_SAVE
                       && !OUTPUT_ENABLED_IN) begin
            st_q <= fac_pkg::ST_SAVE;
          end else if (cap_en && STORE_WR_IN && STORE_DATA_IN == `FAC_STORE_LOAD) begin
            st_q <= fac_pkg::ST_LOAD;
          end else if (cap_en && CAP_RD_IN) begin
            idx_q <= 5'd0;
            st_q <= fac_pkg::ST_READ;
          end
        end
        fac_pkg::ST_SAVE: begin
          if (tmr_done) begin
            st_q <= fac_pkg::ST_IDLE;
          end
        end
        fac_pkg::ST_LOAD: st_q <= fac_pkg::ST_IDLE;
        fac_pkg::ST_READ: begin
          idx_q <= idx_q + 5'd1;
          if (idx_q == 5'(`FAC_CAP_BYTES - 1)) begin
            st_q <= fac_pkg::ST_IDLE;
          end
        end
        default: st_q <= fac_pkg::ST_IDLE;
      endcase
    end
  end

  // ram follows live data while capture is on, except during a readout or while a loaded set is held for readout
  logic held_q;
  always_ff @(posedge MCLK_IN) begin
    for (int i = 0; i < `FAC_CAP_BYTES; i++) begin
      if (st_q == fac_pkg::ST_LOAD) begin
        ram_q[i] <= nvm_q[i];
      end else if (cap_en && !held_q && st_q != fac_pkg::ST_READ) begin
        ram_q[i] <= live[i];
      end
      if (st_q == fac_pkg::ST_SAVE && tmr_done) begin
        nvm_q[i] <= ram_q[i];
      end
    end
  end
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 1'b0;
    end else if (st_q == fac_pkg::ST_LOAD) begin
      held_q <= 1'b1;
    end else if (st_q == fac_pkg::ST_READ && idx_q == 5'(`FAC_CAP_BYTES - 1)) begin
      held_q <= 1'b0;
    end
  end

  // readout and status
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CAP_BYTE_OUT <= 8'h00;
      CAP_VALID_OUT <= 1'b0;
      CAP_LAST_OUT <= 1'b0;
      NVM_BUSY_OUT <= 1'b0;
      INIT_DONE_OUT <= 1'b0;
    end else begin
      CAP_VALID_OUT <= (st_q == fac_pkg::ST_READ);
      CAP_BYTE_OUT <= (st_q == fac_pkg::ST_READ) ? ram_q[idx_q] : 8'h00;
      CAP_LAST_OUT <= (st_q == fac_pkg::ST_READ) && idx_q == 5'(`FAC_CAP_BYTES - 1);
      NVM_BUSY_OUT <= (st_q == fac_pkg::ST_SAVE);
      INIT_DONE_OUT <= (st_q != fac_pkg::ST_INIT);
    end
  end

  // configuration source; user store wins, factory restore may be barred
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CFG_SRC_OUT <= 2'(fac_pkg::SRC_NONE);
      RESTORE_DONE_OUT <= 1'b0;
    end else begin
      RESTORE_DONE_OUT <= 1'b0;
      if (st_q == fac_pkg::ST_INIT && init_q == 5'(`FAC_INIT_CYC - 1)) begin
        CFG_SRC_OUT <= USER_STORED_IN ? 2'(fac_pkg::SRC_USER) :
                       DEFAULT_STORED_IN ? 2'(fac_pkg::SRC_DEFAULT) :
                       2'(fac_pkg::SRC_NONE);
      end else if (st_q != fac_pkg::ST_INIT && RESTORE_DEFAULT_IN && DEFAULT_STORED_IN) begin
        CFG_SRC_OUT <= 2'(fac_pkg::SRC_DEFAULT);
        RESTORE_DONE_OUT <= 1'b1;
      end else if (st_q != fac_pkg::ST_INIT && RESTORE_FACTORY_IN && FACTORY_ALLOWED_IN) begin
        CFG_SRC_OUT <= 2'(fac_pkg::SRC_NONE);
        RESTORE_DONE_OUT <= 1'b1;
      end
    end
  end

  chk_alert_on_fault: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (|(act & ~flt_prev_q)) |=> ##1 FAULT_ALERT_LINE_OE_OUT) else $error("alert not driven");
  chk_alert_holds: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (alert_q && act != 8'h00) |=> alert_q) else $error("alert released with faults");
  chk_alert_release: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (alert_q && ack_q && act == 8'h00 && !(|(act & ~flt_prev_q))) |=> !alert_q)
    else $error("alert not released");
  chk_tlm_live: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (TLM_SEL_IN == 3'd0) |=> TLM_DATA_OUT == $past(VIN_IN)) else $error("telemetry stale");
  chk_read_len: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    $rose(CAP_VALID_OUT) |-> ##21 CAP_LAST_OUT) else $error("block length wrong");
  chk_cap_gate: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (st_q == fac_pkg::ST_IDLE && !cap_en) |=> st_q == fac_pkg::ST_IDLE)
    else $error("capture active while disabled");
  chk_save_disabled: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (st_q == fac_pkg::ST_IDLE && !auto_save && OUTPUT_ENABLED_IN) |=> st_q != fac_pkg::ST_SAVE)
    else $error("save while enabled");
  chk_retry_nosave: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (st_q == fac_pkg::ST_IDLE && !STORE_WR_IN && (act & FAULT_SHUTDOWN_IN) == 8'h00)
    |=> st_q != fac_pkg::ST_SAVE) else $error("retry fault saved");
  chk_save_min: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    $rose(tmr_start) |=> tmr_start [*8]) else $error("save too short");
  chk_load_held: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    (st_q == fac_pkg::ST_LOAD) |=> held_q) else $error("load not held");
endmodule // fac_top
`default_nettype wire

/* src/fac_params.svh */
// constants for the fault alert and capture block
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH
`define FAC_CLK_MHZ 25
`define FAC_SAVE_MIN_US 700
`define FAC_SAVE_MAX_US 1400
`define FAC_SAVE_MIN_CYC (`FAC_SAVE_MIN_US * `FAC_CLK_MHZ)
`define FAC_SAVE_MAX_CYC (`FAC_SAVE_MAX_US * `FAC_CLK_MHZ)
`define FAC_CAP_BYTES 22
`define FAC_MISC_CAP_BIT 1
`define FAC_STORE_LOAD 8'h01
`define FAC_STORE_SAVE 8'h02
`define FAC_NFAULT 8
`define FAC_INIT_CYC 16
`endif

/* src/fac_pkg.sv */
// types for the fault alert and capture block
package fac_pkg;
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_SAVE, ST_LOAD, ST_READ
  } fac_state_type;
  typedef enum logic [1:0] {
    SRC_DEFAULT, SRC_USER, SRC_NONE
  } fac_src_type;
endpackage

/* src/fac_nvm_timer.sv */
// save duration timer for the non-volatile capture store
`timescale 1ns/1ps
`default_nettype none
`include "fac_params.svh"
module fac_nvm_timer #(
  parameter int SAVE_MIN = `FAC_SAVE_MIN_CYC,
  parameter int SAVE_MAX = `FAC_SAVE_MAX_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic block_in,
  output logic done_out
);
  logic [15:0] cnt_q;
  logic busy_q;
  // block prepared data takes the long figure
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (start_in && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= block_in ? 16'(SAVE_MAX - 1) : 16'(SAVE_MIN - 1);
    end else if (busy_q) begin
      if (cnt_q == 16'h0000) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
  assign done_out = busy_q && (cnt_q == 16'h0000);
endmodule // fac_nvm_timer
`default_nettype wire

/* tb/fac_host_model.sv */
// host controller model that answers the alert line
`timescale 1ns/1ps
`default_nettype none
module fac_host_model (
  input wire logic clk_in,
  input wire logic alert_line_n_in,
  input wire logic [7:0] gap_in,
  output logic ara_ack_out
);
  logic [7:0] cnt_q;
  initial ara_ack_out = 1'b0;
  initial cnt_q = 8'h00;
  // keep querying while the line stays low, several devices may share it
  always @(posedge clk_in) begin
    ara_ack_out <= 1'b0;
    if (alert_line_n_in || ara_ack_out) cnt_q <= 8'h00;
    else if (cnt_q >= gap_in) begin
      ara_ack_out <= 1'b1;
      cnt_q <= 8'h00;
    end else cnt_q <= cnt_q + 8'h01;
  end
endmodule // fac_host_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the fault alert and capture block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SMIN = 20;
  localparam int SMAX = 40;
  logic clk = 1'b0, rst_n = 1'b0, out_en = 1'b0, ack, swr = 1'b0, bprep = 1'b0, cap_rd = 1'b0;
  logic rdef = 1'b0, rfac = 1'b0, fallow = 1'b0, dstore = 1'b1, ustore = 1'b0;
  logic [7:0] fault = 8'h00, fen = 8'h00, fsd = 8'h00, misc = 8'h00, sdata = 8'h00, gap = 8'h05;
  logic [5:0][15:0] tv = '0;
  logic [5:0][15:0] saved;
  logic [2:0] sel = 3'h0;
  logic line_n, oe, cval, clast, busy, idone, rdone;
  logic [15:0] tlm;
  logic [7:0] cbyte;
  logic [1:0] src;
  logic [7:0] expq[$];
  int miscompares = 0, tests_run = 0, nbyte = 0, n;
  bit hit;
  wire logic wire_n = oe ? line_n : 1'b1; // pulled up when nobody drives
  always #20 clk = ~clk;
  fac_top #(.SAVE_MIN(SMIN), .SAVE_MAX(SMAX)) i_fac_top (.MCLK_IN(clk), .RESETN_IN(rst_n),
    .FAULT_IN(fault), .FAULT_ALERT_EN_IN(fen), .FAULT_SHUTDOWN_IN(fsd),
    .OUTPUT_ENABLED_IN(out_en), .ARA_ACK_IN(ack), .FAULT_ALERT_LINE_N_OUT(line_n),
    .FAULT_ALERT_LINE_OE_OUT(oe), .VIN_IN(tv[0]), .VOUT_IN(tv[1]), .IOUT_IN(tv[2]),
    .TEMP_IN(tv[3]), .FREQ_IN(tv[4]), .DUTY_IN(tv[5]), .TLM_SEL_IN(sel), .TLM_DATA_OUT(tlm),
    .MISC_SETUP_IN(misc), .STORE_WR_IN(swr), .STORE_DATA_IN(sdata), .BLOCK_PREP_IN(bprep),
    .CAP_RD_IN(cap_rd), .CAP_BYTE_OUT(cbyte), .CAP_VALID_OUT(cval), .CAP_LAST_OUT(clast),
    .NVM_BUSY_OUT(busy), .DEFAULT_STORED_IN(dstore), .USER_STORED_IN(ustore),
    .RESTORE_DEFAULT_IN(rdef), .RESTORE_FACTORY_IN(rfac), .FACTORY_ALLOWED_IN(fallow),
    .CFG_SRC_OUT(src), .INIT_DONE_OUT(idone), .RESTORE_DONE_OUT(rdone));
  fac_host_model i_fac_host_model (.clk_in(clk), .alert_line_n_in(wire_n), .gap_in(gap),
    .ara_ack_out(ack));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return busy;
      1: return oe;
      2: return rdone;
      3: return cval;
      default: return idone;
    endcase
  endfunction
  task automatic wait_sig(input int w, input logic lvl, input int lim, output bit h);
    h = 0;
    // look in the current cycle first so that one-cycle pulses are not missed
    for (int i = 0; i < lim && !h; i++) begin
      #1 h = (sig(w) === lvl);
      if (!h) @(posedge clk);
    end
  endtask
  // a missed handshake ends the run instead of hanging it
  task automatic need(input int w, input logic lvl, input int lim);
    bit h;
    wait_sig(w, lvl, lim, h);
    if (!h) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic pulse(input int w);
    @(posedge clk) case (w)
      0: cap_rd <= 1'b1;
      1: rdef <= 1'b1;
      default: rfac <= 1'b1;
    endcase
    @(posedge clk) {cap_rd, rdef, rfac} <= 3'b000;
  endtask
  task automatic store(input logic [7:0] d);
    @(posedge clk) begin
      swr <= 1'b1;
      sdata <= d;
    end
    @(posedge clk) swr <= 1'b0;
  endtask
  task automatic read_cap(input logic [5:0][15:0] v);
    for (int i = 0; i < 22; i++) expq.push_back(i < 12 ? v[i / 2][8 * (i % 2) +: 8] : 8'h00);
    pulse(0);
    need(3, 1'b1, 6);
    need(3, 1'b0, 30);
    check("bytes left", 16'(expq.size()), 16'h0000);
  endtask
  always @(negedge clk) if (cval === 1'b1) begin
    check("capture byte", {8'h00, cbyte},
          {8'h00, expq.size() > 0 ? expq.pop_front() : 8'hxx});
    check("last flag", {15'h0, clast}, {15'h0, nbyte == 21});
    nbyte = (clast === 1'b1) ? 0 : nbyte + 1;
  end
  initial begin
    void'($urandom(32'h1b6771a6));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tv <= {$urandom(), $urandom(), $urandom()};
    need(4, 1'b1, 40);
    check("config source", {14'h0, src}, 16'h0000);
    for (int s = 0; s < 7; s++) begin
      @(posedge clk) sel <= 3'(s);
      repeat (3) @(posedge clk);
      #1 check("telemetry", tlm, s < 6 ? tv[s] : 16'h0000);
    end
    pulse(0);
    wait_sig(3, 1'b1, 30, hit);
    check("readout while off", {15'h0, hit}, 16'h0000);
    @(posedge clk) misc <= 8'h02;
    read_cap(tv);
    @(posedge clk) out_en <= 1'b1;
    store(8'h02);
    wait_sig(0, 1'b1, 10, hit);
    check("save while enabled", {15'h0, hit}, 16'h0000);
    @(posedge clk) out_en <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk) bprep <= b[0];
      store(8'h02);
      need(0, 1'b1, 3);
      for (n = 0; busy === 1'b1 && n < 100; n++) #40;
      check("save length", 16'(n - (b ? SMAX : SMIN)) <= 16'h1 ? 16'h1 : 16'h0, 16'h1);
    end
    saved = tv;
    @(posedge clk) tv <= {$urandom(), $urandom(), $urandom()};
    store(8'h01);
    read_cap(saved);
    read_cap(tv);
    @(posedge clk) begin
      fen <= 8'h03;
      fsd <= 8'h01;
      fault <= 8'h02;
    end
    need(1, 1'b1, 8);
    check("alert level", {15'h0, wire_n}, 16'h0000);
    wait_sig(0, 1'b1, 40, hit);
    check("retry fault save", {15'h0, hit}, 16'h0000);
    check("alert held", {15'h0, oe}, 16'h0001);
    @(posedge clk) fault <= 8'h00;
    need(1, 1'b0, 30);
    check("alert released", {15'h0, wire_n}, 16'h0001);
    @(posedge clk) fault <= 8'h04;
    wait_sig(1, 1'b1, 10, hit);
    check("unenabled alert", {15'h0, hit}, 16'h0000);
    @(posedge clk) fault <= 8'h05;
    need(0, 1'b1, 8);
    @(posedge clk) fault <= 8'h00;
    need(0, 1'b0, 2 * SMAX + 10);
    need(1, 1'b0, 30);
    pulse(2);
    wait_sig(2, 1'b1, 10, hit);
    check("factory restore", {15'h0, hit}, 16'h0000);
    // second reset with a user store present: user settings take precedence
    @(posedge clk) begin
      ustore <= 1'b1;
      rst_n <= 1'b0;
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    need(4, 1'b1, 40);
    check("user source", {14'h0, src}, 16'h0001);
    pulse(1);
    need(2, 1'b1, 10);
    check("default restore", {14'h0, src}, 16'h0000);
    @(posedge clk) fallow <= 1'b1;
    pulse(2);
    need(2, 1'b1, 10);
    check("factory source", {14'h0, src}, 16'h0002);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
